// [commutator_pkg.sv]
// Shared constants and carrier types for the telemetry commutator and framer
package commutator_pkg;
    // Time-sharing scan geometry
    localparam int PRIMARY_SLOTS = 30;
    localparam int SUBMUX_SLOTS = 23;
    localparam int DATA_SLOTS = 27;
    localparam int SUB_CHANNELS = 10;
    localparam int PRIMARY_RATE_HZ = 120;
    localparam int CAL_LEVELS = 5;
    localparam int CAL_TIME_MS = 400;
    localparam int DIGITAL_INPUTS = 100;
    localparam int WORD_BITS = 10;
    // Slot rate and the cycle count per slot at 100 MHz
    localparam int CLK_HZ = 100000000;
    localparam int SLOT_HZ = PRIMARY_SLOTS * PRIMARY_RATE_HZ;
    localparam int SLOT_CYCLES = CLK_HZ / SLOT_HZ;
    // Frame word order: analog slot word, digital word, discrete word
    localparam logic [1:0] PHASE_ANALOG = 2'h0;
    localparam logic [1:0] PHASE_DIGITAL = 2'h1;
    localparam logic [1:0] PHASE_DISCRETE = 2'h2;
    localparam logic [1:0] PHASE_LAST = 2'h2;
    // Reference slot levels, calibration levels
    localparam logic [9:0] REF_ZERO = 10'h000;
    localparam logic [9:0] REF_MID = 10'h200;
    localparam logic [9:0] REF_FULL = 10'h3ff;
    localparam logic [9:0] CAL_STEP = 10'h0ff;
    localparam logic [4:0] SLOT_RESET = 5'h00;
    localparam logic [3:0] SUB_RESET = 4'h0;

    typedef struct packed {
        logic [9:0] data;
        logic [4:0] slot;
        logic [3:0] sub;
        logic [1:0] phase;
        logic cal;
    } frame_word_s;

    typedef enum logic [2:0] {
        CAL_IDLE = 3'b001,
        CAL_WAIT = 3'b010,
        CAL_RUN = 3'b100
    } cal_state_e;

    // Calibration level n as a 10-bit value
    function automatic logic [9:0] cal_level(input logic [2:0] n);
        cal_level = 10'(({7'h00, n}) * CAL_STEP);
    endfunction
endpackage

// [word_store.sv]
// Temporary storage for the remote digital multiplexer's 10-bit words
`timescale 1ns/1ps
module word_store (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Write port
    input wire logic wr_en_in,
    input wire logic [6:0] wr_addr_in,
    input wire logic [9:0] wr_data_in,
    // Read port, data registered
    input wire logic [6:0] rd_addr_in,
    output logic [9:0] rd_data_out
);
    import commutator_pkg::*;
    logic [9:0] mem [0:DIGITAL_INPUTS-1];

    // Store write, no reset on the array to keep it a plain RAM
    always_ff @(posedge clk_in) begin
        if (wr_en_in && (wr_addr_in < 7'(DIGITAL_INPUTS))) begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    // Registered read
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rd_data_out <= 10'h000;
        end else if (rd_addr_in < 7'(DIGITAL_INPUTS)) begin
            rd_data_out <= mem[rd_addr_in];
        end else begin
            rd_data_out <= 10'h000;
        end
    end
endmodule // word_store

// [skid_buffer.sv]
// Two-entry buffer between the framer and the serial stage
`timescale 1ns/1ps
module skid_buffer (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Fill side
    input wire logic in_valid_in,
    input commutator_pkg::frame_word_s in_word_in,
    output logic in_ready_out,
    // Drain side
    output logic out_valid_out,
    output commutator_pkg::frame_word_s out_word_out,
    input wire logic out_ready_in
);
    import commutator_pkg::*;
    frame_word_s slot0_reg;
    frame_word_s slot1_reg;
    logic [1:0] count_reg;
    wire push = in_valid_in && in_ready_out;
    wire pop = out_valid_out && out_ready_in;

    // Entry 0 is the head; entry 1 catches a word while the head stalls
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            slot0_reg <= '0;
            slot1_reg <= '0;
            count_reg <= 2'h0;
            in_ready_out <= 1'b1;
            out_valid_out <= 1'b0;
        end else begin
            if (pop) begin
                slot0_reg <= (count_reg == 2'h2) ? slot1_reg : in_word_in;
            end else if (push && count_reg == 2'h0) begin
                slot0_reg <= in_word_in;
            end
            if (push && ((count_reg == 2'h1 && !pop) || (count_reg == 2'h2))) begin
                slot1_reg <= in_word_in;
            end
            count_reg <= 2'(count_reg + {1'b0, push} - {1'b0, pop});
            in_ready_out <= (2'(count_reg + {1'b0, push} - {1'b0, pop}) != 2'h2);
            out_valid_out <= (2'(count_reg + {1'b0, push} - {1'b0, pop}) != 2'h0);
        end
    end
    assign out_word_out = slot0_reg;
endmodule // skid_buffer

// [telemetry_commutator_framer.sv]
// Time-sharing commutator, calibration sequencer and serial framer
// Function
// - Scan thirty primary slots cyclically, each slot 120 times per second.
// - Slots 0 to 22 may be sub-multiplexed among slower inputs.
// - Sub-multiplexed slots rotate over ten sub-channels, 12 samples per second.
// - Slots 0 to 26 carry measurements; slots 27 to 29 carry references.
// - A calibration request waits for the next master frame boundary.
// - Calibration blocks measurements and substitutes five levels on data slots.
// - Each level lasts one master frame; five frames total.
// - The digital multiplexer accepts up to 100 inputs, discretes or data.
// - Digital inputs are held as 10-bit words, then framed.
// - Digitized analog, digital words and discretes interleave into one stream.
// - The serial stream also goes to ground checkout equipment when enabled.
// - Serializer may take the other stage's analog; local analog routes out.
`timescale 1ns/1ps
module telemetry_commutator_framer (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Digitized analog sample for the addressed slot, local and other stage
    input wire logic [9:0] local_sample_in,
    input wire logic [9:0] other_stage_sample_in,
    input wire logic use_other_stage_in,
    // Remote digital multiplexer inputs
    input wire logic digital_wr_in,
    input wire logic [6:0] digital_addr_in,
    input wire logic [9:0] digital_data_in,
    // Direct discrete inputs, pins
    input wire logic [9:0] discrete_in,
    // Calibration request, a pin
    input wire logic cal_request_in,
    // Checkout enable, a pin
    input wire logic checkout_enable_in,
    // Sample address to the conditioners
    output logic [4:0] slot_out,
    output logic [3:0] sub_channel_out,
    output logic slot_strobe_out,
    output logic master_frame_out,
    output logic cal_active_out,
    output logic [2:0] cal_level_out,
    // Local analog sample handed to the other stage
    output logic [9:0] cross_stage_sample_out,
    // Serial stream to transmitter and ground checkout
    output logic pcm_link_data_out,
    output logic pcm_link_valid_out,
    output logic pcm_link_frame_out,
    output logic ground_checkout_equipment_data_out,
    output logic ground_checkout_equipment_valid_out
);
    import commutator_pkg::*;

    // Pin synchronisers: three stages, change taken when stages two and three agree
    logic [2:0] cal_sync_reg;
    logic [2:0] chk_sync_reg;
    logic cal_req_reg;
    logic chk_en_reg;
    logic [9:0] disc_s1_reg;
    logic [9:0] disc_s2_reg;
    logic [9:0] disc_s3_reg;
    logic [9:0] disc_reg;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cal_sync_reg <= 3'h0;
            chk_sync_reg <= 3'h0;
            cal_req_reg <= 1'b0;
            chk_en_reg <= 1'b0;
        end else begin
            cal_sync_reg <= {cal_sync_reg[1:0], cal_request_in};
            chk_sync_reg <= {chk_sync_reg[1:0], checkout_enable_in};
            if (cal_sync_reg[1] == cal_sync_reg[2]) cal_req_reg <= cal_sync_reg[2];
            if (chk_sync_reg[1] == chk_sync_reg[2]) chk_en_reg <= chk_sync_reg[2];
        end
    end

    // Discretes take a word only where every bit has settled
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            disc_s1_reg <= 10'h000;
            disc_s2_reg <= 10'h000;
            disc_s3_reg <= 10'h000;
            disc_reg <= 10'h000;
        end else begin
            disc_s1_reg <= discrete_in;
            disc_s2_reg <= disc_s1_reg;
            disc_s3_reg <= disc_s2_reg;
            if (disc_s2_reg == disc_s3_reg) disc_reg <= disc_s3_reg;
        end
    end

    // Slot timer and scan counters
    logic [15:0] tick_reg;
    logic [4:0] slot_reg;
    logic [3:0] sub_reg;
    wire tick_end = (tick_reg == 16'(SLOT_CYCLES - 1));
    wire slot_end = (slot_reg == 5'(PRIMARY_SLOTS - 1));
    wire sub_end = (sub_reg == 4'(SUB_CHANNELS - 1));
    wire master_end = tick_end && slot_end && sub_end;

    // Each slot lasts SLOT_CYCLES so every slot recurs 120 times a second
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tick_reg <= 16'h0000;
            slot_reg <= SLOT_RESET;
            sub_reg <= SUB_RESET;
        end else begin
            tick_reg <= tick_end ? 16'h0000 : 16'(tick_reg + 16'h0001);
            if (tick_end) begin
                slot_reg <= slot_end ? SLOT_RESET : 5'(slot_reg + 5'h01);
                if (slot_end) sub_reg <= sub_end ? SUB_RESET : 4'(sub_reg + 4'h1);
            end
        end
    end

    // Calibration sequencer
    cal_state_e cal_state_reg;
    cal_state_e cal_state_next;
    logic [2:0] level_reg;
    logic [2:0] level_next;
    wire last_level = (level_reg == 3'(CAL_LEVELS - 1));

    // Request is held until a master boundary; the run spans five master frames
    always_comb begin
        cal_state_next = cal_state_reg;
        level_next = level_reg;
        case (cal_state_reg)
            CAL_IDLE: begin
                if (cal_req_reg) cal_state_next = CAL_WAIT;
            end
            CAL_WAIT: begin
                if (master_end) begin
                    cal_state_next = CAL_RUN;
                    level_next = 3'h0;
                end
            end
            CAL_RUN: begin
                if (master_end) begin
                    if (last_level) cal_state_next = CAL_IDLE;
                    else level_next = 3'(level_reg + 3'h1);
                end
            end
            default: cal_state_next = CAL_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cal_state_reg <= CAL_IDLE;
            level_reg <= 3'h0;
        end else begin
            cal_state_reg <= cal_state_next;
            level_reg <= level_next;
        end
    end

    // Digital word store
    logic [9:0] digital_word;
    logic [6:0] digital_rd_addr;
    word_store store_inst (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .wr_en_in(digital_wr_in),
        .wr_addr_in(digital_addr_in),
        .wr_data_in(digital_data_in),
        .rd_addr_in(digital_rd_addr),
        .rd_data_out(digital_word)
    );

    // Digital inputs are read round-robin, one per slot
    logic [6:0] dig_ptr_reg;
    assign digital_rd_addr = dig_ptr_reg;
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            dig_ptr_reg <= 7'h00;
        end else if (tick_end) begin
            dig_ptr_reg <= (dig_ptr_reg == 7'(DIGITAL_INPUTS - 1)) ? 7'h00 : 7'(dig_ptr_reg + 7'h01);
        end
    end

    // Slot content selection
    wire cal_run = (cal_state_reg == CAL_RUN);
    wire is_data_slot = (slot_reg < 5'(DATA_SLOTS));
    wire [9:0] analog_in = use_other_stage_in ? other_stage_sample_in : local_sample_in;
    wire [9:0] ref_word = (slot_reg == 5'(DATA_SLOTS)) ? REF_ZERO :
                          (slot_reg == 5'(DATA_SLOTS + 1)) ? REF_MID : REF_FULL;
    wire [9:0] data_word = cal_run ? cal_level(level_reg) : analog_in;
    wire [9:0] slot_word = is_data_slot ? data_word : ref_word;
    wire [3:0] sub_tag = (slot_reg < 5'(SUBMUX_SLOTS)) ? sub_reg : SUB_RESET;

    // Word emission: three words per slot, analog then digital then discrete
    logic [1:0] phase_reg;
    logic emit_reg;
    frame_word_s word_reg;
    logic buf_ready;
    wire emit_take = emit_reg && buf_ready;
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            phase_reg <= PHASE_ANALOG;
            emit_reg <= 1'b0;
            word_reg <= '0;
        end else if (tick_end) begin
            // Slot start: capture analog word; a stalled word is dropped only if the sink stalls a whole slot
            emit_reg <= 1'b1;
            phase_reg <= PHASE_ANALOG;
            word_reg <= '{data: slot_word, slot: slot_reg, sub: sub_tag, phase: PHASE_ANALOG, cal: cal_run};
        end else if (emit_take) begin
            if (phase_reg == PHASE_LAST) begin
                emit_reg <= 1'b0;
            end else begin
                phase_reg <= 2'(phase_reg + 2'h1);
                word_reg.phase <= 2'(phase_reg + 2'h1);
                word_reg.data <= (phase_reg == PHASE_ANALOG) ? digital_word : disc_reg;
            end
        end
    end

    frame_word_s buf_word;
    logic buf_valid;
    logic ser_ready;
    skid_buffer buffer_inst (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .in_valid_in(emit_reg),
        .in_word_in(word_reg),
        .in_ready_out(buf_ready),
        .out_valid_out(buf_valid),
        .out_word_out(buf_word),
        .out_ready_in(ser_ready)
    );

    // Serializer, MSB first, one bit per clock
    logic [9:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    logic busy_reg;
    logic first_reg;
    assign ser_ready = !busy_reg;
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            shift_reg <= 10'h000;
            bit_cnt_reg <= 4'h0;
            busy_reg <= 1'b0;
            first_reg <= 1'b0;
        end else if (!busy_reg && buf_valid) begin
            shift_reg <= buf_word.data;
            bit_cnt_reg <= 4'(WORD_BITS - 1);
            busy_reg <= 1'b1;
            first_reg <= (buf_word.slot == SLOT_RESET) && (buf_word.phase == PHASE_ANALOG);
        end else if (busy_reg) begin
            shift_reg <= {shift_reg[8:0], 1'b0};
            bit_cnt_reg <= 4'(bit_cnt_reg - 4'h1);
            first_reg <= 1'b0;
            if (bit_cnt_reg == 4'h0) busy_reg <= 1'b0;
        end
    end

    // Registered outputs; ground copy only while checkout is enabled
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pcm_link_data_out <= 1'b0;
            pcm_link_valid_out <= 1'b0;
            pcm_link_frame_out <= 1'b0;
            ground_checkout_equipment_data_out <= 1'b0;
            ground_checkout_equipment_valid_out <= 1'b0;
            slot_out <= SLOT_RESET;
            sub_channel_out <= SUB_RESET;
            slot_strobe_out <= 1'b0;
            master_frame_out <= 1'b0;
            cal_active_out <= 1'b0;
            cal_level_out <= 3'h0;
            cross_stage_sample_out <= 10'h000;
        end else begin
            pcm_link_data_out <= busy_reg & shift_reg[9];
            pcm_link_valid_out <= busy_reg;
            pcm_link_frame_out <= first_reg;
            ground_checkout_equipment_data_out <= chk_en_reg & busy_reg & shift_reg[9];
            ground_checkout_equipment_valid_out <= chk_en_reg & busy_reg;
            slot_out <= slot_reg;
            sub_channel_out <= sub_tag;
            slot_strobe_out <= tick_end;
            master_frame_out <= master_end;
            cal_active_out <= cal_run;
            cal_level_out <= level_reg;
            cross_stage_sample_out <= local_sample_in;
        end
    end
endmodule // telemetry_commutator_framer

// [commutator_monitor.sv]
// Concurrent checks on the commutator's slot timing, calibration and serial stream
`timescale 1ns/1ps
module commutator_monitor import commutator_pkg::*; (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Watched ports
    input wire logic [9:0] local_sample_in,
    input wire logic [4:0] slot_out,
    input wire logic [3:0] sub_channel_out,
    input wire logic slot_strobe_out,
    input wire logic master_frame_out,
    input wire logic cal_active_out,
    input wire logic [2:0] cal_level_out,
    input wire logic [9:0] cross_stage_sample_out,
    input wire logic pcm_link_data_out,
    input wire logic pcm_link_valid_out,
    input wire logic pcm_link_frame_out,
    input wire logic ground_checkout_equipment_data_out,
    input wire logic ground_checkout_equipment_valid_out
);
    logic [14:0] gap_reg;
    logic seen_reg;
    logic [3:0] run_reg;

    // Cycles since the last strobe; the first strobe after reset has no reference
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            gap_reg <= 15'h0000;
            seen_reg <= 1'b0;
            run_reg <= 4'h0;
        end else begin
            gap_reg <= slot_strobe_out ? 15'h0000 : gap_reg + 15'h0001;
            seen_reg <= seen_reg | slot_strobe_out;
            // Length of the current run of valid bits; a stuck valid trips the limit before it wraps
            run_reg <= pcm_link_valid_out ? 4'(run_reg + 4'h1) : 4'h0;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    slot_range_a: assert property (slot_out <= 5'd29) else $error("slot out of range");
    slot_step_a: assert property ($changed(slot_out) |->
        slot_out == (($past(slot_out) == 5'd29) ? 5'd0 : $past(slot_out) + 5'd1)) else $error("slot skipped");
    slot_time_a: assert property (slot_strobe_out && seen_reg |->
        gap_reg == 15'(SLOT_CYCLES - 1)) else $error("slot length wrong");
    sub_zero_a: assert property (slot_out > 5'd22 |-> sub_channel_out == 4'h0) else $error("sub on plain slot");
    sub_range_a: assert property (sub_channel_out <= 4'd9) else $error("sub out of range");
    master_align_a: assert property (master_frame_out |-> slot_strobe_out) else $error("master off slot");
    cal_start_a: assert property ($rose(cal_active_out) |->
        master_frame_out || $past(master_frame_out)) else $error("calibration off boundary");
    cal_level_a: assert property (cal_level_out <= 3'd4) else $error("bad cal level");
    word_len_a: assert property ($fell(pcm_link_valid_out) |->
        run_reg == 4'd10) else $error("word length wrong");
    word_max_a: assert property (run_reg <= 4'd10) else $error("word too long");
    frame_bit_a: assert property (pcm_link_frame_out |-> $rose(pcm_link_valid_out)) else $error("frame flag late");
    cross_copy_a: assert property (!$past(sys_rst_in) |->
        cross_stage_sample_out == $past(local_sample_in)) else $error("cross copy wrong");
    ground_copy_a: assert property (ground_checkout_equipment_valid_out |-> pcm_link_valid_out &&
        ground_checkout_equipment_data_out == pcm_link_data_out) else $error("ground copy wrong");

    // Main scenarios reached
    cover property (slot_strobe_out && seen_reg);
    cover property (pcm_link_frame_out);
    cover property (ground_checkout_equipment_valid_out);
endmodule // commutator_monitor

bind telemetry_commutator_framer commutator_monitor monitor (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .local_sample_in(local_sample_in), .slot_out(slot_out), .sub_channel_out(sub_channel_out),
    .slot_strobe_out(slot_strobe_out), .master_frame_out(master_frame_out), .cal_active_out(cal_active_out),
    .cal_level_out(cal_level_out), .cross_stage_sample_out(cross_stage_sample_out),
    .pcm_link_data_out(pcm_link_data_out), .pcm_link_valid_out(pcm_link_valid_out),
    .pcm_link_frame_out(pcm_link_frame_out),
    .ground_checkout_equipment_data_out(ground_checkout_equipment_data_out),
    .ground_checkout_equipment_valid_out(ground_checkout_equipment_valid_out));

// [far_side_model.sv]
// Far-side model: conditioners answering the slot address, transmitter gathering words
`timescale 1ns/1ps
module far_side_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Address from the commutator, bias set by the bench
    input wire logic [4:0] slot_in,
    input wire logic [3:0] sub_in,
    input wire logic [9:0] bias_in,
    output logic [9:0] sample_out,
    output logic [9:0] other_out,
    // Serial stream in, words out
    input wire logic bit_in,
    input wire logic bit_valid_in,
    input wire logic frame_in,
    output logic [10:0] word_out,
    output logic word_valid_out
);
    logic [10:0] shift_reg;
    logic [3:0] count_reg;

    // Samples depend on the address, so a wrong slot or sub shows as a wrong word
    assign sample_out = bias_in ^ {1'b0, slot_in, sub_in};
    assign other_out = ~sample_out;
    assign word_out = shift_reg;

    // Ten bits MSB first; the frame flag of the first bit rides on top
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            shift_reg <= 11'h000;
            count_reg <= 4'h0;
            word_valid_out <= 1'b0;
        end else begin
            word_valid_out <= bit_valid_in && (count_reg == 4'h9);
            if (bit_valid_in) begin
                shift_reg <= (count_reg == 4'h0) ? {frame_in, 9'h000, bit_in} : {shift_reg[10], shift_reg[8:0], bit_in};
                count_reg <= (count_reg == 4'h9) ? 4'h0 : count_reg + 4'h1;
            end
        end
    end
endmodule // far_side_model

// [tb.sv]
// Self-checking bench: slot sampling, word order, serial framing and ground copy
`timescale 1ns/1ps
module tb;
    import commutator_pkg::*;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [9:0] local_sample_in, other_stage_sample_in, cross_stage_sample_out;
    logic [9:0] bias_q = 10'h000;
    logic [9:0] digital_data_in = 10'h000;
    logic [9:0] discrete_in = 10'h000;
    logic [6:0] digital_addr_in = 7'h00;
    logic use_other_stage_in = 1'b0;
    logic digital_wr_in = 1'b0;
    logic cal_request_in = 1'b0;
    logic checkout_enable_in = 1'b0;
    logic [4:0] slot_out;
    logic [3:0] sub_channel_out;
    logic [2:0] cal_level_out;
    logic slot_strobe_out, master_frame_out, cal_active_out, pcm_link_data_out, pcm_link_valid_out;
    logic pcm_link_frame_out, ground_checkout_equipment_data_out, ground_checkout_equipment_valid_out;
    logic [10:0] rx_word;
    logic rx_valid;
    logic [10:0] exp_q[$];
    int errors = 0;
    int n_compared = 0;

    always #5 clk_in = ~clk_in;

    telemetry_commutator_framer dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .local_sample_in(local_sample_in),
        .other_stage_sample_in(other_stage_sample_in), .use_other_stage_in(use_other_stage_in),
        .digital_wr_in(digital_wr_in), .digital_addr_in(digital_addr_in), .digital_data_in(digital_data_in),
        .discrete_in(discrete_in), .cal_request_in(cal_request_in), .checkout_enable_in(checkout_enable_in),
        .slot_out(slot_out), .sub_channel_out(sub_channel_out), .slot_strobe_out(slot_strobe_out),
        .master_frame_out(master_frame_out), .cal_active_out(cal_active_out), .cal_level_out(cal_level_out),
        .cross_stage_sample_out(cross_stage_sample_out), .pcm_link_data_out(pcm_link_data_out),
        .pcm_link_valid_out(pcm_link_valid_out), .pcm_link_frame_out(pcm_link_frame_out),
        .ground_checkout_equipment_data_out(ground_checkout_equipment_data_out),
        .ground_checkout_equipment_valid_out(ground_checkout_equipment_valid_out));

    far_side_model partner (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .slot_in(slot_out), .sub_in(sub_channel_out),
        .bias_in(bias_q), .sample_out(local_sample_in), .other_out(other_stage_sample_in),
        .bit_in(pcm_link_data_out), .bit_valid_in(pcm_link_valid_out), .frame_in(pcm_link_frame_out),
        .word_out(rx_word), .word_valid_out(rx_valid));

    // One place for every comparison
    task automatic check(input string what, input logic [10:0] seen, input logic [10:0] expected);
        n_compared++;
        if (seen !== expected) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, expected, seen);
        end
    endtask

    task automatic stop_test();
        if (errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Bounded wait for the end of a slot; a slot is far longer than any word burst
    task automatic wait_strobe();
        for (int i = 0; i <= 30000; i++) begin
            @(posedge clk_in);
            if (slot_strobe_out === 1'b1) begin
                return;
            end
        end
        check("slot strobe", 11'h000, 11'h001);
        stop_test();
    endtask

    // Each received word is matched against the oldest note; ground copy follows the stream
    always @(posedge clk_in) begin
        if (rx_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("spare word", rx_word, 11'hxxx);
            end else begin
                check("word", rx_word, exp_q.pop_front());
            end
        end
        if (pcm_link_valid_out === 1'b1) begin
            check("ground copy", {9'h000, ground_checkout_equipment_valid_out, ground_checkout_equipment_data_out},
                {9'h000, checkout_enable_in, checkout_enable_in & pcm_link_data_out});
        end
    end

    initial begin
        logic [9:0] store [4];
        logic [9:0] an, b, d;
        logic u;
        void'($urandom(32'h8aadf967));
        repeat (3) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_in);
        #1;
        check("reset", {slot_out, sub_channel_out, pcm_link_valid_out, ground_checkout_equipment_valid_out}, 11'h000);
        // Fill the first store words, then two writes past the top that must be ignored
        for (int a = 0; a < 6; a++) begin
            @(posedge clk_in);
            an = 10'($urandom);
            if (a < 4) begin
                store[a] = an;
            end
            digital_wr_in <= 1'b1;
            digital_addr_in <= (a < 4) ? 7'(a) : 7'(96 + a);
            digital_data_in <= an;
        end
        @(posedge clk_in);
        digital_wr_in <= 1'b0;
        // Three slots with fresh samples, stage choice, discretes and checkout setting
        for (int s = 0; s < 3; s++) begin
            @(posedge clk_in);
            b = 10'($urandom);
            u = 1'($urandom);
            d = 10'($urandom);
            bias_q <= b;
            use_other_stage_in <= u;
            discrete_in <= d;
            checkout_enable_in <= (s != 1);
            cal_request_in <= (s == 1);
            an = b ^ {1'b0, 5'(s), 4'h0};
            exp_q.push_back({s == 0, u ? ~an : an});
            exp_q.push_back({1'b0, store[s]});
            exp_q.push_back({1'b0, d});
            wait_strobe();
            repeat (100) @(posedge clk_in);
            check("next slot", {2'h0, sub_channel_out, slot_out}, 11'(s + 1));
            check("cal idle", {7'h00, cal_active_out, cal_level_out}, 11'h000);
            check("cross stage", {1'b0, cross_stage_sample_out}, {1'b0, b ^ {1'b0, 5'(s + 1), 4'h0}});
        end
        for (int i = 0; i < 200 && exp_q.size() > 0; i++) begin
            @(posedge clk_in);
        end
        check("words left", 11'(exp_q.size()), 11'h000);
        stop_test();
    end
endmodule // tb
